// File: rtl/sram_host_defs.svh
// Widths and timing counts for the static RAM host controller
`ifndef SRAM_HOST_DEFS_SVH
`define SRAM_HOST_DEFS_SVH

`define SRAM_ADDR_W     18
`define SRAM_DATA_W     8
`define CLK_PERIOD_NS   20
`define T_RC_NS         70
`define T_PWE_NS        50
`define T_HZOE_NS       25
`define RC_CYC          ((`T_RC_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PWE_CYC         ((`T_PWE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HZ_CYC          ((`T_HZOE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_CYC        4
`define CNT_W           4

`endif

// File: rtl/sram_host_pkg.sv
// Types shared by the static RAM host controller
package sram_host_pkg;
    typedef enum {
        IDLE,
        RD_ACCESS,
        RD_SYNC,
        WR_SETUP,
        WR_PULSE,
        WR_HOLD
    } state_t;
    typedef logic [17:0] addr_t;
    typedef logic [7:0]  byte_t;
endpackage

// File: rtl/pin_sync.sv
// Three-flop pin synchroniser that passes a value once the last two stages agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 8
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    always_comb
    begin
        next_q = q;
        if (s2 == s3)
            next_q = s3;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end
        else
        begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule // pin_sync

// File: rtl/sram_host.sv
// Host-side controller driving an asynchronous 256K x 8 static RAM
`timescale 1ns/1ps
`include "sram_host_defs.svh"
module sram_host (
    input  wire logic                 ref_clk,
    input  wire logic                 resetn,
    input  wire logic                 req,
    input  wire logic                 req_write,
    input  wire sram_host_pkg::addr_t req_addr,
    input  wire sram_host_pkg::byte_t req_wdata,
    output sram_host_pkg::byte_t      rsp_rdata,
    output logic                      rsp_valid,
    output logic                      ready,
    output sram_host_pkg::addr_t      addr_lines,
    output logic                      select_low_n,
    output logic                      select_high,
    output logic                      write_n,
    output logic                      gate_n,
    input  wire sram_host_pkg::byte_t data_lines_in,
    output sram_host_pkg::byte_t      data_lines_out,
    output logic                      data_lines_oe
);
    import sram_host_pkg::*;

    state_t              state;
    state_t              next_state;
    logic [`CNT_W-1:0]   cnt;
    logic [`CNT_W-1:0]   next_cnt;
    addr_t               next_addr_lines;
    logic                next_select_low_n;
    logic                next_select_high;
    logic                next_write_n;
    logic                next_gate_n;
    byte_t               next_data_lines_out;
    logic                next_data_lines_oe;
    byte_t               next_rsp_rdata;
    logic                next_rsp_valid;
    logic                next_ready;
    byte_t               data_synced;

    pin_sync #(
        .W (`SRAM_DATA_W)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .d       (data_lines_in),
        .q       (data_synced)
    );

    function automatic logic [`CNT_W-1:0] cyc(input int n);
        cyc = `CNT_W'(n - 1);
    endfunction

    always_comb
    begin
        next_state          = state;
        next_cnt            = cnt;
        next_addr_lines     = addr_lines;
        next_select_low_n   = select_low_n;
        next_select_high    = select_high;
        next_write_n        = write_n;
        next_gate_n         = gate_n;
        next_data_lines_out = data_lines_out;
        next_data_lines_oe  = data_lines_oe;
        next_rsp_rdata      = rsp_rdata;
        next_rsp_valid      = 1'b0;
        case (state)
            IDLE:
            begin
                if (req)
                begin
                    // Address changes with the select edge, then holds until IDLE
                    next_addr_lines   = req_addr;
                    next_select_low_n = 1'b0;
                    next_select_high  = 1'b1;
                    next_write_n      = 1'b1;
                    if (req_write)
                    begin
                        // Gate stays high so the RAM never drives into us
                        next_gate_n         = 1'b1;
                        next_data_lines_out = req_wdata;
                        next_cnt            = cyc(`HZ_CYC);
                        next_state          = WR_SETUP;
                    end
                    else
                    begin
                        next_gate_n = 1'b0;
                        next_cnt    = cyc(`RC_CYC);
                        next_state  = RD_ACCESS;
                    end
                end
            end
            RD_ACCESS:
            begin
                if (cnt == '0)
                begin
                    next_cnt   = cyc(`SYNC_CYC);
                    next_state = RD_SYNC;
                end
                else
                    next_cnt = cnt - 1'b1;
            end
            RD_SYNC:
            begin
                if (cnt == '0)
                begin
                    next_rsp_rdata    = data_synced;
                    next_rsp_valid    = 1'b1;
                    next_gate_n       = 1'b1;
                    next_select_low_n = 1'b1;
                    next_select_high  = 1'b0;
                    next_state        = IDLE;
                end
                else
                    next_cnt = cnt - 1'b1;
            end
            WR_SETUP:
            begin
                // Waits out the RAM output turn-off before driving
                if (cnt == '0)
                begin
                    next_write_n       = 1'b0;
                    next_data_lines_oe = 1'b1;
                    next_cnt           = cyc(`PWE_CYC);
                    next_state         = WR_PULSE;
                end
                else
                    next_cnt = cnt - 1'b1;
            end
            WR_PULSE:
            begin
                if (cnt == '0)
                begin
                    // Strobe ends the write; select and data kept one more cycle
                    next_write_n = 1'b1;
                    next_state   = WR_HOLD;
                end
                else
                    next_cnt = cnt - 1'b1;
            end
            WR_HOLD:
            begin
                // Data hold past the strobe edge is a full cycle
                next_data_lines_oe = 1'b0;
                next_select_low_n  = 1'b1;
                next_select_high   = 1'b0;
                next_state         = IDLE;
            end
            default:
            begin
                next_state = IDLE;
            end
        endcase
        next_ready = (next_state == IDLE);
    end

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state          <= IDLE;
            cnt            <= '0;
            addr_lines     <= '0;
            select_low_n   <= 1'b1;
            select_high    <= 1'b0;
            write_n        <= 1'b1;
            gate_n         <= 1'b1;
            data_lines_out <= '0;
            data_lines_oe  <= 1'b0;
            rsp_rdata      <= '0;
            rsp_valid      <= 1'b0;
            ready          <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            cnt            <= next_cnt;
            addr_lines     <= next_addr_lines;
            select_low_n   <= next_select_low_n;
            select_high    <= next_select_high;
            write_n        <= next_write_n;
            gate_n         <= next_gate_n;
            data_lines_out <= next_data_lines_out;
            data_lines_oe  <= next_data_lines_oe;
            rsp_rdata      <= next_rsp_rdata;
            rsp_valid      <= next_rsp_valid;
            ready          <= next_ready;
        end
    end

    logic sel_act;
    assign sel_act = !select_low_n && select_high;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence seq_strobe_low;
        !write_n [*3];
    endsequence
    sequence seq_strobe_end;
        write_n && sel_act && data_lines_oe;
    endsequence

    AST_WRITE_OVERLAP: assert property (
        !write_n |-> sel_act && data_lines_oe)
        else $error("write strobe low without select or data");
    AST_READ_RESPONSE: assert property (
        $fell(gate_n) |-> sel_act ##8 rsp_valid)
        else $error("read response not on time");
    AST_PULSE_SHAPE: assert property (
        $fell(write_n) |-> seq_strobe_low ##1 seq_strobe_end)
        else $error("write strobe pulse wrong length or end");
    AST_DATA_HOLD: assert property (
        $rose(write_n) |-> data_lines_oe && $stable(data_lines_out))
        else $error("write data not held across strobe rise");
    AST_NO_CONTENTION: assert property (
        $rose(gate_n) |-> !data_lines_oe [*2])
        else $error("driving data during RAM turn-off");
    AST_GATE_IN_WRITE: assert property (
        data_lines_oe |-> gate_n)
        else $error("data driven with output gate low");
    AST_ADDR_AT_SELECT: assert property (
        sel_act && $past(sel_act) |-> $stable(addr_lines))
        else $error("address moved while selected");
    AST_STROBE_IN_READ: assert property (
        !gate_n |-> write_n)
        else $error("write strobe low during read");
    AST_ADDR_IN_WRITE: assert property (
        $fell(write_n) |=> $stable(addr_lines) [*3])
        else $error("address moved during write overlap");
endmodule // sram_host

// File: verif/sram_device_model.sv
// Behavioural model of the 256K x 8 static RAM on the far side of the host
`timescale 1ns/1ps
module sram_device_model (
    input  wire sram_host_pkg::addr_t addr_lines,
    input  wire logic                 select_low_n,
    input  wire logic                 select_high,
    input  wire logic                 write_n,
    input  wire logic                 gate_n,
    input  wire sram_host_pkg::byte_t bus,
    input  wire logic                 slow,
    output sram_host_pkg::byte_t      dq_out,
    output logic                      dq_oe
);
    import sram_host_pkg::*;
    byte_t mem [addr_t];
    int    wr_count = 0;
    addr_t addr_late;
    wire   rd_late;
    wire   sel = ~select_low_n & select_high;
    wire   wr  = sel & ~write_n;
    wire   rd  = sel & write_n & ~gate_n;
    // Slow answers still settle inside the 70 ns read window
    assign #(slow ? 60 : 5) rd_late = rd;
    always @(addr_lines) addr_late <= #(slow ? 60 : 5) addr_lines;
    // Off at once, on only after the access time
    always @* dq_oe = rd & rd_late;
    always @(addr_late or wr_count)
    begin
        dq_out = mem.exists(addr_late) ? mem[addr_late] : ~addr_late[7:0];
    end
    // Stored when the first of strobe or select rises
    always @(negedge wr)
    begin
        if (!$isunknown(addr_lines))
        begin
            mem[addr_lines] = bus;
            wr_count++;
        end
    end
endmodule // sram_device_model

// File: verif/tb_top.sv
// Self-checking testbench for the static RAM host controller
`timescale 1ns/1ps
`include "sram_host_defs.svh"
module tb_top;
    import sram_host_pkg::*;
    logic  ref_clk = 1'b0, resetn = 1'b0, req = 1'b0, req_write = 1'b0, slow = 1'b0;
    logic  rsp_valid, ready, select_low_n, select_high, write_n, gate_n, data_lines_oe, dq_oe;
    logic  prev_wr = 1'b0;
    addr_t req_addr = '0, addr_lines, prev_addr;
    byte_t req_wdata = '0, rsp_rdata, data_lines_out, dq_out, bus;
    byte_t float_val = 8'h5a;
    byte_t shadow [addr_t];
    addr_t used [$];
    int    err_count = 0, compares = 0;

    always #10 ref_clk = ~ref_clk;
    // Undriven lines wander so a stale value never passes for data
    assign bus = (data_lines_oe && dq_oe) ? 8'hxx : data_lines_oe ? data_lines_out
                 : dq_oe ? dq_out : float_val;

    sram_host dut (.ref_clk(ref_clk), .resetn(resetn), .req(req), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .rsp_rdata(rsp_rdata),
        .rsp_valid(rsp_valid), .ready(ready), .addr_lines(addr_lines),
        .select_low_n(select_low_n), .select_high(select_high), .write_n(write_n),
        .gate_n(gate_n), .data_lines_in(bus), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe));
    sram_device_model ram (.addr_lines(addr_lines), .select_low_n(select_low_n),
        .select_high(select_high), .write_n(write_n), .gate_n(gate_n), .bus(bus),
        .slow(slow), .dq_out(dq_out), .dq_oe(dq_oe));

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge ref_clk)
    begin
        if (!data_lines_oe && !dq_oe)
            float_val <= ~float_val;
        if (resetn)
        begin
            if (data_lines_oe === 1'b1) check("contention", dq_oe, 1'b0);
            if (gate_n === 1'b0) check("strobe_in_read", write_n, 1'b1);
            if (prev_wr && write_n === 1'b0) check("addr_in_write", addr_lines, prev_addr);
        end
        prev_wr <= ~select_low_n & select_high & ~write_n;
        prev_addr <= addr_lines;
    end

    // Extra cycles keep req up with other values while the controller is busy
    task automatic issue(input logic w, input addr_t a, input byte_t d, input int extra);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 50)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 50) check("ready_wait", n, 0);
        req = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(negedge ref_clk);
        repeat (extra)
        begin
            req_addr = a ^ 18'h00001;
            req_wdata = ~d;
            @(negedge ref_clk);
        end
        req = 1'b0;
    endtask

    task automatic do_write(input addr_t a, input byte_t d, input int extra);
        issue(1'b1, a, d, extra);
        shadow[a] = d;
        used.push_back(a);
    endtask

    task automatic do_read(input addr_t a);
        int n;
        issue(1'b0, a, 8'h00, 0);
        n = 0;
        while (rsp_valid !== 1'b1 && n < 30)
        begin
            @(negedge ref_clk);
            n++;
        end
        check("read_valid", rsp_valid, 1'b1);
        check("read_latency", n, `RC_CYC + `SYNC_CYC);
        check("read_data", rsp_rdata, shadow[a]);
    endtask

    initial
    begin
        void'($urandom(78));
        repeat (16) @(negedge ref_clk);
        resetn = 1'b1;
        do_write(18'h00000, 8'h00, 0);
        do_write(18'h3ffff, 8'hff, 0);
        do_read(18'h00000);
        do_read(18'h3ffff);
        do_write(18'h10101, 8'h77, 0);
        do_write(18'h10100, 8'h3c, 3);
        do_read(18'h10101);
        do_read(18'h10100);
        repeat (80)
        begin
            slow = 1'($urandom);
            if ($urandom % 2)
                do_write(addr_t'($urandom & 32'h0ffff), byte_t'($urandom), 0);
            else
                do_read(used[$urandom % used.size()]);
        end
        issue(1'b1, 18'h2aaaa, 8'h99, 0);
        @(negedge ref_clk);
        resetn = 1'b0;
        @(negedge ref_clk);
        check("reset_pins", {select_low_n, select_high, write_n, gate_n, data_lines_oe,
            rsp_valid, ready}, 7'h58);
        resetn = 1'b1;
        do_read(18'h3ffff);
        summarize();
    end

    initial
    begin
        #(20 * 20000);
        err_count++;
        summarize();
    end
endmodule // tb_top
